// ===== b3c_pkg.sv
package b3c_pkg;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_HW_CONTROL = 16'h4061;
	localparam logic [15:0] IDX_ON_CONFIG = 16'h4062;
	localparam logic [15:0] IDX_SLEEP_CONTROL = 16'h4063;
	localparam logic [15:0] IDX_STATUS = 16'h40F0;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	// field positions
	localparam int SLOT_LSB = 13;
	localparam int MODE_LSB = 8;
	localparam int VSEL_LSB = 0;
	localparam int HW_VCHOICE_BIT = 10;
	localparam int FOLLOWER_BIT = 13;
	// reset values
	localparam logic [2:0] START_SLOT_RST = 3'h0;
	localparam logic [1:0] ACTIVE_MODE_RST = 2'h1;
	localparam logic [6:0] ACTIVE_VCODE_RST = 7'h00;
	localparam logic [2:0] SLEEP_SLOT_RST = 3'h0;
	localparam logic [1:0] SLEEP_MODE_RST = 2'h3;
	localparam logic [6:0] SLEEP_VCODE_RST = 7'h00;
	// start slot codes
	localparam logic [2:0] START_NEVER = 3'h0;
	localparam logic [2:0] START_HW1 = 3'h6;
	localparam logic [2:0] START_HW2 = 3'h7;
	// sleep slot codes
	localparam logic [2:0] SLEEP_XN_SLOT5 = 3'h0;
	localparam logic [2:0] SLEEP_XN_SLOT3 = 3'h6;
	localparam logic [2:0] SLEEP_XN_SLOT1 = 3'h7;
	localparam logic [2:0] SLOT_SIX = 3'h6;
	localparam logic [2:0] SLOT_FIVE = 3'h5;
	localparam logic [2:0] SLOT_THREE = 3'h3;
	localparam logic [2:0] SLOT_ONE = 3'h1;
	// voltage coding: 0.85V plus 25mV per code, codes from 66h read as 3.4V
	localparam int VBASE_MV = 850;
	localparam int VSTEP_MV = 25;
	localparam logic [6:0] VCODE_SAT = 7'h66;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		OPM_FORCED_CCM,
		OPM_AUTO,
		OPM_LDO,
		OPM_HYSTERETIC
	} b3c_opmode_t;

	typedef struct packed
	{
		logic enable;
		logic [1:0] op_mode;
		logic [6:0] voltage_code;
	} b3c_conv_t;

	typedef struct packed
	{
		logic [2:0] start_slot;
		logic [1:0] active_op_mode;
		logic [4:0] active_vcode_hi;
		logic [2:0] sleep_slot;
		logic [1:0] sleep_op_mode;
		logic [6:0] sleep_vcode;
		logic follower_select;
	} b3c_nvm_t;
endpackage : b3c_pkg

// ===== b3c_regs.sv
// Operation
// - start slot in bits 15:13 resets to 000 (never on), 001-101 turn on in slots 1-5, 110/111 hand control to hardware enable 1/2.
// - active mode in bits 9:8 resets to 01 auto; 00 forced continuous, 10 linear, 11 hysteretic.
// - the 7-bit active voltage code sits in bits 6:2 and 1:0, 0.85V plus 25mV a code, saturating at 3.4V from 66h.
// - only bits 6:2 of the active code come from non-volatile load; bits 1:0 reset to 00, are cleared to 00 by a load and are set only by register write.
// - sleep slot in bits 15:13 resets to 000 (sleep transition in slot 5), 001-101 turn off in slots 5 down to 1, 110 slot 3, 111 slot 1.
// - under hardware enable, sleep codes 001-101 pick the slot where the converter enters sleep instead of turning off.
// - sleep mode in bits 9:8 resets to 11 hysteretic, same coding as the active mode.
// - sleep voltage code in bits 6:0 resets to 0 and uses the same coding as the active code.
// - with the follower select set, the fourth converter takes the same slot, mode and voltage as this one.
// - under hardware control, bit 10 picks the active code when clear and the sleep code when set.
`timescale 1ns/10ps
module b3c_regs
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [b3c_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [b3c_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [b3c_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [b3c_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic nvm_load,
	input wire b3c_pkg::b3c_nvm_t nvm_data,
	input wire logic seq_slot_pulse,
	input wire logic [2:0] seq_slot,
	input wire logic seq_sleep_dir,
	input wire logic hw_enable1_pin,
	input wire logic hw_enable2_pin,
	output b3c_pkg::b3c_conv_t buck3_out,
	output b3c_pkg::b3c_conv_t buck4_out
);
	import b3c_pkg::*;
	typedef enum logic [1:0] {ST_OFF, ST_ON, ST_SLEEP} b3c_state_t;
	localparam logic [2:0] SEL_NONE = 3'h0;
	logic [2:0] start_slot_q, sleep_slot_q;
	logic [1:0] active_mode_q, sleep_mode_q;
	logic [6:0] active_vcode_q, sleep_vcode_q;
	logic follower_q, hw_vchoice_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [DATA_W-1:0] rdata_q, wdata_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [3:0] wstrb_q;
	logic [2:0] hw1_sync_q, hw2_sync_q;
	logic hw1_q, hw2_q;
	b3c_state_t state_q;
	b3c_conv_t buck3_q, buck4_q;
	logic wr_fire, hw_ctrl, hw_level, sleep_turns_off;
	logic [2:0] wsel, sleep_at;
	b3c_conv_t conv_d;

	// binary-coded register select, shared by read and write paths
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [2:0] s;
		s = 3'h0;
		if (a[1:0] == 2'h0)
		begin
			if (a[ADDR_W-1:2] == (ADDR_W-2)'(IDX_HW_CONTROL)) s = 3'h1;
			if (a[ADDR_W-1:2] == (ADDR_W-2)'(IDX_ON_CONFIG)) s = 3'h2;
			if (a[ADDR_W-1:2] == (ADDR_W-2)'(IDX_SLEEP_CONTROL)) s = 3'h3;
			if (a[ADDR_W-1:2] == (ADDR_W-2)'(IDX_STATUS)) s = 3'h4;
		end
		return s;
	endfunction : reg_sel
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign buck3_out = buck3_q;
	assign buck4_out = buck4_q;
	// write channel: address and data accepted in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && awready_q)
			begin
				awaddr_q <= s_axi_awaddr;
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid && wready_q)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				wready_q <= 1'b0;
			end
			if (wr_fire)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= (wsel == SEL_NONE || wsel == 3'h4) ? RESP_SLVERR : RESP_OKAY;
			end
			if (bvalid_q && s_axi_bready)
			begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end
	assign wr_fire = !awready_q && !wready_q && !bvalid_q;
	assign wsel = reg_sel(awaddr_q);
	// configuration fields; a bus write in the same cycle as a load wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			start_slot_q <= START_SLOT_RST;
			active_mode_q <= ACTIVE_MODE_RST;
			active_vcode_q <= ACTIVE_VCODE_RST;
			sleep_slot_q <= SLEEP_SLOT_RST;
			sleep_mode_q <= SLEEP_MODE_RST;
			sleep_vcode_q <= SLEEP_VCODE_RST;
			follower_q <= 1'b0;
			hw_vchoice_q <= 1'b0;
		end
		else if (wr_fire && wsel != SEL_NONE)
		begin
			if (wsel == 3'h1 && wstrb_q[1])
				hw_vchoice_q <= wdata_q[HW_VCHOICE_BIT];
			if (wsel == 3'h2)
			begin
				if (wstrb_q[1])
				begin
					start_slot_q <= wdata_q[SLOT_LSB +: 3];
					active_mode_q <= wdata_q[MODE_LSB +: 2];
				end
				if (wstrb_q[0])
					active_vcode_q <= wdata_q[VSEL_LSB +: 7];
			end
			if (wsel == 3'h3)
			begin
				if (wstrb_q[1])
				begin
					sleep_slot_q <= wdata_q[SLOT_LSB +: 3];
					sleep_mode_q <= wdata_q[MODE_LSB +: 2];
				end
				if (wstrb_q[0])
					sleep_vcode_q <= wdata_q[VSEL_LSB +: 7];
			end
		end
		else if (nvm_load)
		begin
			start_slot_q <= nvm_data.start_slot;
			active_mode_q <= nvm_data.active_op_mode;
			// low two bits are not held in non-volatile memory
			active_vcode_q <= {nvm_data.active_vcode_hi, 2'h0};
			sleep_slot_q <= nvm_data.sleep_slot;
			sleep_mode_q <= nvm_data.sleep_op_mode;
			sleep_vcode_q <= nvm_data.sleep_vcode;
			follower_q <= nvm_data.follower_select;
		end
	end
	// read channel: data one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
		end
		else if (s_axi_arvalid && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			case (reg_sel(s_axi_araddr))
				3'h1: rdata_q[HW_VCHOICE_BIT] <= hw_vchoice_q;
				3'h2: rdata_q[15:0] <= {start_slot_q, 3'h0, active_mode_q, 1'b0, active_vcode_q};
				3'h3: rdata_q[15:0] <= {sleep_slot_q, 3'h0, sleep_mode_q, 1'b0, sleep_vcode_q};
				3'h4: rdata_q[15:0] <= {2'h0, follower_q, 1'b0, 2'(state_q), hw2_q, hw1_q, 8'(buck3_q)};
				default: rresp_q <= RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end
	// enable pins: three flops, level accepted when the last two agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hw1_sync_q <= 3'h0;
			hw2_sync_q <= 3'h0;
			hw1_q <= 1'b0;
			hw2_q <= 1'b0;
		end
		else
		begin
			hw1_sync_q <= {hw1_sync_q[1:0], hw_enable1_pin};
			hw2_sync_q <= {hw2_sync_q[1:0], hw_enable2_pin};
			if (hw1_sync_q[1] == hw1_sync_q[2])
				hw1_q <= hw1_sync_q[2];
			if (hw2_sync_q[1] == hw2_sync_q[2])
				hw2_q <= hw2_sync_q[2];
		end
	end
	assign hw_ctrl = (start_slot_q == START_HW1) || (start_slot_q == START_HW2);
	assign hw_level = (start_slot_q == START_HW1) ? hw1_q : hw2_q;
	// codes 001..101 count down from slot 5 to slot 1
	assign sleep_turns_off = (sleep_slot_q != SLEEP_XN_SLOT5) && (sleep_slot_q < SLOT_SIX);
	always_comb
	begin
		case (sleep_slot_q)
			SLEEP_XN_SLOT5: sleep_at = SLOT_FIVE;
			SLEEP_XN_SLOT3: sleep_at = SLOT_THREE;
			SLEEP_XN_SLOT1: sleep_at = SLOT_ONE;
			default: sleep_at = 3'(SLOT_SIX - sleep_slot_q);
		endcase
	end
	// converter state, advanced by the sequencer's slot strobes, or by the enable pin under hardware control
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_q <= ST_OFF;
		else if (hw_ctrl)
		begin
			// pin decides on or off; sleep slot only moves it into sleep
			if (!hw_level)
				state_q <= ST_OFF;
			else if (seq_slot_pulse && seq_sleep_dir && seq_slot == sleep_at)
				state_q <= ST_SLEEP;
			else if (seq_slot_pulse && !seq_sleep_dir)
				state_q <= ST_ON;
			else if (state_q == ST_OFF)
				state_q <= ST_ON;
		end
		else if (seq_slot_pulse)
		begin
			if (!seq_sleep_dir && start_slot_q != START_NEVER && seq_slot == start_slot_q)
				state_q <= ST_ON;
			else if (seq_sleep_dir && state_q == ST_ON && seq_slot == sleep_at)
				state_q <= sleep_turns_off ? ST_OFF : ST_SLEEP;
		end
		else if (start_slot_q == START_NEVER)
			state_q <= ST_OFF;
	end
	always_comb
	begin
		conv_d.enable = (state_q != ST_OFF);
		conv_d.op_mode = active_mode_q;
		conv_d.voltage_code = active_vcode_q;
		if (state_q == ST_SLEEP)
		begin
			conv_d.op_mode = sleep_mode_q;
			conv_d.voltage_code = sleep_vcode_q;
		end
		else if (hw_ctrl && hw_vchoice_q)
			conv_d.voltage_code = sleep_vcode_q;
	end
	// outputs registered; follower mirrors this converter or stays off
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			buck3_q <= '0;
			buck4_q <= '0;
		end
		else
		begin
			buck3_q <= conv_d;
			buck4_q <= follower_q ? conv_d : '0;
		end
	end
endmodule : b3c_regs

// ===== b3c_regs_asserts.sv
`timescale 1ns/10ps
module b3c_regs_asserts
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [b3c_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [b3c_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic seq_slot_pulse,
	input wire logic hw_enable1_pin,
	input wire logic hw_enable2_pin,
	input wire b3c_pkg::b3c_conv_t buck3_out,
	input wire b3c_pkg::b3c_conv_t buck4_out
);
	import b3c_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_b_rise;
		// fields and the response both land on the second edge after the take
		disable iff (!aresetn) s_wr_take |-> ##2 s_axi_bvalid;
	endproperty
	a_b_rise: assert property (p_b_rise) else $error("write not answered");
	property p_b_hold;
		disable iff (!aresetn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_rise;
		disable iff (!aresetn) s_rd_take |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_rise: assert property (p_r_rise) else $error("read not answered");
	property p_r_hold;
		disable iff (!aresetn) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data moved");
	// only the far side of the map is checked, cheap and unambiguous
	property p_r_err;
		disable iff (!aresetn) s_rd_take and s_axi_araddr[19:2] > 18'h040F0
			|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_r_err: assert property (p_r_err) else $error("unmapped read accepted");
	property p_rst;
		!aresetn |=> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid
			&& buck3_out == 10'h0 && buck4_out == 10'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_b4;
		disable iff (!aresetn) buck4_out == 10'h0 || buck4_out == buck3_out;
	endproperty
	a_b4: assert property (p_b4) else $error("follower differs");
	property p_en_rise;
		disable iff (!aresetn) $rose(buck3_out.enable)
			|-> $past(seq_slot_pulse, 2) || hw_enable1_pin || hw_enable2_pin;
	endproperty
	a_en_rise: assert property (p_en_rise) else $error("enable without cause");
endmodule : b3c_regs_asserts
bind b3c_regs b3c_regs_asserts b3c_regs_asserts_inst (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .seq_slot_pulse, .hw_enable1_pin, .hw_enable2_pin, .buck3_out, .buck4_out);

// ===== b3c_seq_model.sv
`timescale 1ns/10ps
module b3c_seq_model
(
	input wire logic aclk,
	output logic seq_slot_pulse,
	output logic [2:0] seq_slot,
	output logic seq_sleep_dir
);
	initial
	begin
		seq_slot_pulse = 1'b0;
		seq_slot = 3'h0;
		seq_sleep_dir = 1'b0;
	end
	// slot and direction carry junk between pulses, never a held value
	task automatic run(input logic d);
		int i;
		for (i = 1; i <= 5; i++)
		begin
			@(posedge aclk);
			seq_slot_pulse <= 1'b1;
			seq_slot <= d ? 3'(6 - i) : 3'(i);
			seq_sleep_dir <= d;
			@(posedge aclk);
			seq_slot_pulse <= 1'b0;
			seq_slot <= ~seq_slot;
			seq_sleep_dir <= ~d;
		end
	endtask : run
endmodule : b3c_seq_model

// ===== buck3_sequence_voltage_config_tb.sv
`timescale 1ns/10ps
module buck3_sequence_voltage_config_tb;
	import b3c_pkg::*;
	logic aclk, aresetn, nvm_load, seq_slot_pulse, seq_sleep_dir, hw_enable1_pin, hw_enable2_pin;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [2:0] seq_slot;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	b3c_nvm_t nvm_data;
	b3c_conv_t buck3_out, buck4_out;
	int n_fail, check_count, seed, mon, msl, i;
	b3c_regs b3c_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .nvm_load, .nvm_data, .seq_slot_pulse, .seq_slot,
		.seq_sleep_dir, .hw_enable1_pin, .hw_enable2_pin, .buck3_out, .buck4_out);
	b3c_seq_model b3c_seq_model_inst (.aclk, .seq_slot_pulse, .seq_slot, .seq_sleep_dir);
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic lim(input int k);
		if (k == 50)
		begin
			n_fail++;
			print_verdict();
		end
	endtask : lim
	task automatic wr(input logic [15:0] ix, input logic [31:0] d);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= 20'({ix, 2'h0});
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		lim(k);
	endtask : wr
	task automatic rd(input logic [15:0] ix);
		int k;
		@(posedge aclk);
		s_axi_araddr <= 20'({ix, 2'h0});
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		lim(k);
	endtask : rd
	task automatic rc(input logic [15:0] ix, input int e);
		rd(ix);
		chk(rv, 32'(e));
	endtask : rc
	// converter word from a register image: enable, mode, voltage code
	function automatic logic [31:0] cv(input int r);
		return {22'h0, 1'b1, r[9:8], r[6:0]};
	endfunction : cv
	task automatic seq(input logic d);
		b3c_seq_model_inst.run(d);
		repeat (3) @(posedge aclk);
	endtask : seq
	initial
	begin
		seed = 32'h22885be1;
		n_fail = 0;
		check_count = 0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr,
			s_axi_arvalid, s_axi_rready, nvm_load, nvm_data, hw_enable1_pin, hw_enable2_pin} = '0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rc(IDX_ON_CONFIG, 32'h100);
		rc(IDX_SLEEP_CONTROL, 32'h300);
		$display("test reset done");
		for (i = 0; i < 4; i++)
		begin
			mon = $random(seed);
			msl = $random(seed);
			wr(IDX_ON_CONFIG, mon);
			chk(rr, RESP_OKAY);
			wr(IDX_SLEEP_CONTROL, msl);
			rc(IDX_ON_CONFIG, mon & 32'hE37F);
			rc(IDX_SLEEP_CONTROL, msl & 32'hE37F);
		end
		s_axi_wstrb <= 4'h1;
		wr(IDX_ON_CONFIG, 32'hFFFF);
		s_axi_wstrb <= 4'hF;
		rc(IDX_ON_CONFIG, (mon & 32'hE300) | 32'h7F);
		$display("test fields done");
		wr(16'h4100, 32'hFFFF);
		chk(rr, RESP_SLVERR);
		wr(IDX_STATUS, 32'hFFFF);
		chk(rr, RESP_SLVERR);
		rd(16'h4100);
		chk(rr, RESP_SLVERR);
		$display("test refusal done");
		wr(IDX_ON_CONFIG, 32'h0105);
		seq(1'b0);
		chk(32'(buck3_out.enable), 32'h0);
		mon = 32'h6066;
		msl = 32'h0212;
		wr(IDX_ON_CONFIG, mon);
		wr(IDX_SLEEP_CONTROL, msl);
		seq(1'b0);
		chk(32'(buck3_out), cv(mon));
		seq(1'b1);
		chk(32'(buck3_out), cv(msl));
		wr(IDX_SLEEP_CONTROL, 32'h2300);
		seq(1'b0);
		seq(1'b1);
		chk(32'(buck3_out.enable), 32'h0);
		$display("test sequence done");
		wr(IDX_ON_CONFIG, 32'h0003);
		@(posedge aclk);
		nvm_data <= {3'h2, 2'h3, 5'h1F, 3'h7, 2'h0, 7'h11, 1'b1};
		nvm_load <= 1'b1;
		@(posedge aclk);
		nvm_load <= 1'b0;
		mon = 32'h437C;
		msl = 32'hE011;
		rc(IDX_ON_CONFIG, mon);
		rc(IDX_SLEEP_CONTROL, msl);
		seq(1'b0);
		chk(32'(buck4_out), cv(mon));
		seq(1'b1);
		chk(32'(buck4_out), cv(msl));
		rc(IDX_STATUS, 32'h2811);
		$display("test load done");
		mon = 32'hC105;
		msl = 32'h2333;
		wr(IDX_ON_CONFIG, mon);
		wr(IDX_SLEEP_CONTROL, msl);
		hw_enable1_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(32'(buck3_out), cv(mon));
		wr(IDX_HW_CONTROL, 32'h0400);
		repeat (3) @(posedge aclk);
		chk(32'(buck3_out), cv((mon & 32'hFF80) | (msl & 32'h7F)));
		wr(IDX_HW_CONTROL, 32'h0);
		seq(1'b1);
		chk(32'(buck3_out), cv(msl));
		hw_enable1_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		chk(32'(buck3_out.enable), 32'h0);
		$display("test hardware done");
		print_verdict();
	end
endmodule : buck3_sequence_voltage_config_tb
